/* core/fspc_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "fspc_defs.vh"

module fspc_ctrl #(
    parameter APP_TOP = 16'h47ff,
    parameter BOOT_TOP = 16'h0fff,
    parameter ERASE_CYC = (`FSPC_ERASE_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS,
    parameter PROG_CYC = (`FSPC_PROG_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS,
    parameter READ_CYC = 4,
    parameter [7:0] COMPANY_CODE = 8'h5a, // Arbitrary value
    parameter [15:0] DEVICE_CODE = 16'h1234 // Arbitrary value
) (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Special-function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // Brown-out status from pins (asynchronous)
    input wire brownout_low,
    input wire brownout_detect_enable,
    input wire brownout_reset_enable,
    // CPU side
    input wire [15:0] cpu_fetch_addr,
    output wire secure_area_selected,
    output wire cpu_hold,
    output wire internal_fast_oscillator_on,
    // Flash array port
    output reg flash_req,
    output reg [1:0] flash_area,
    output reg [3:0] flash_func,
    output reg [15:0] flash_addr,
    output reg [7:0] flash_wdata,
    input wire flash_done,
    input wire [7:0] flash_rdata
);

    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [7:0] update_en_q;
    reg [7:0] command_q;
    reg [7:0] addr_hi_q;
    reg [7:0] addr_lo_q;
    reg [7:0] data_q;
    reg [7:0] brownout_cfg_q;
    reg prog_en_q;
    reg fault_q;
    reg trigger_q;
    reg [2:0] state_q;
    reg [2:0] unlock_q;
    reg key1_seen_q;
    reg [22:0] timer_q;
    reg [1:0] bo_low_s_q;
    reg [1:0] bo_det_s_q;
    reg [1:0] bo_rst_s_q;

    wire [15:0] target = {addr_hi_q, addr_lo_q};
    wire [1:0] area = command_q[7:6];
    wire erase_prog = command_q[`FSPC_CMD_ERASE_PROG];
    wire aux = command_q[`FSPC_CMD_AUX];
    wire [3:0] func = command_q[3:0];
    wire unlocked = unlock_q != 3'd0;
    wire bo_low = bo_low_s_q[1];
    wire bo_det = bo_det_s_q[1];
    wire bo_rst = bo_rst_s_q[1];

    // Valid command encodings; ID reads ignore area
    function cmd_valid;
        input [7:0] c;
        begin
            if (c[`FSPC_CMD_AUX])
                cmd_valid = 1'b0;
            else if (c[`FSPC_CMD_ERASE_PROG])
                cmd_valid = (c[3:0] == `FSPC_FN_PROG) || (c[3:0] == `FSPC_FN_ERASE);
            else
                cmd_valid = (c[3:0] == `FSPC_FN_READ) || (c[3:0] == `FSPC_FN_UID) ||
                    (c[3:0] == `FSPC_FN_CID) || (c[3:0] == `FSPC_FN_DID);
        end
    endfunction

    // Address range per area and function
    function addr_ok;
        input [1:0] a;
        input [3:0] f;
        input [15:0] ad;
        begin
            if (f == `FSPC_FN_UID)
                addr_ok = ad <= 16'h000b;
            else if (f == `FSPC_FN_DID)
                addr_ok = ad <= 16'h0001;
            else if (f == `FSPC_FN_CID)
                addr_ok = 1'b1;
            else begin
                case (a)
                    `FSPC_AREA_APP: addr_ok = ad <= APP_TOP;
                    `FSPC_AREA_BOOT: addr_ok = ad <= BOOT_TOP;
                    `FSPC_AREA_SEC: addr_ok = (ad >= `FSPC_SEC_LO) && (ad <= `FSPC_SEC_HI);
                    default: addr_ok = ad <= `FSPC_CFG_HI;
                endcase
            end
        end
    endfunction

    // Region write permission from the update-enable bits
    wire region_ok = (area == `FSPC_AREA_APP) ? update_en_q[`FSPC_UE_APP] :
        (area == `FSPC_AREA_BOOT) ? update_en_q[`FSPC_UE_BOOT] :
        (area == `FSPC_AREA_SEC) ? update_en_q[`FSPC_UE_SEC] :
        update_en_q[`FSPC_UE_CFG];

    wire is_write = erase_prog && !aux;
    // Inhibit only while detection is on and reset is off
    wire bo_block = brownout_cfg_q[`FSPC_CFG2_BOINH] && bo_det && !bo_rst && bo_low;

    wire fault_now = !addr_ok(area, func, target) ||
        !cmd_valid(command_q) ||
        (is_write && !region_ok) ||
        (is_write && bo_block);

    wire wr_cc = sfr_wr && sfr_addr == `FSPC_ADDR_CHIP_CONTROL && unlocked;
    wire wr_ue = sfr_wr && sfr_addr == `FSPC_ADDR_UPDATE_EN && unlocked;
    wire go = sfr_wr && sfr_addr == `FSPC_ADDR_TRIGGER && unlocked && sfr_wdata[0] &&
        prog_en_q && state_q == ST_IDLE;

    assign secure_area_selected = update_en_q[`FSPC_UE_MAP] &&
        (cpu_fetch_addr[15:7] == 9'h1ff);
    assign internal_fast_oscillator_on = prog_en_q;
    assign cpu_hold = trigger_q;

    // Brown-out inputs come from another domain; only the second flop is read
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bo_low_s_q <= 2'b00;
            bo_det_s_q <= 2'b00;
            bo_rst_s_q <= 2'b00;
        end else begin
            bo_low_s_q <= {bo_low_s_q[0], brownout_low};
            bo_det_s_q <= {bo_det_s_q[0], brownout_detect_enable};
            bo_rst_s_q <= {bo_rst_s_q[0], brownout_reset_enable};
        end
    end

    // Timed unlock: two keys open a short write window
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            key1_seen_q <= 1'b0;
            unlock_q <= 3'd0;
        end else begin
            if (sfr_wr && sfr_addr == `FSPC_ADDR_UNLOCK) begin
                key1_seen_q <= sfr_wdata == `FSPC_UNLOCK_KEY1;
                if (key1_seen_q && sfr_wdata == `FSPC_UNLOCK_KEY2)
                    unlock_q <= `FSPC_UNLOCK_WINDOW;
                else
                    unlock_q <= 3'd0;
            end else if (sfr_wr && unlocked) begin
                // One protected write spends the window
                unlock_q <= 3'd0;
                key1_seen_q <= 1'b0;
            end else if (unlocked) begin
                unlock_q <= unlock_q - 3'd1;
            end
        end
    end

    // Plain registers
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            update_en_q <= `FSPC_RST_UPDATE_EN;
            command_q <= `FSPC_RST_COMMAND;
            addr_hi_q <= `FSPC_RST_ADDR;
            addr_lo_q <= `FSPC_RST_ADDR;
            brownout_cfg_q <= `FSPC_RST_BROWNOUT_CFG;
            prog_en_q <= 1'b0;
        end else begin
            if (wr_ue)
                update_en_q <= {3'b000, sfr_wdata[4:0]};
            if (wr_cc)
                prog_en_q <= sfr_wdata[`FSPC_CC_ENABLE];
            if (sfr_wr && sfr_addr == `FSPC_ADDR_COMMAND && !trigger_q)
                command_q <= sfr_wdata;
            if (sfr_wr && sfr_addr == `FSPC_ADDR_ADDR_HIGH && !trigger_q)
                addr_hi_q <= sfr_wdata;
            if (sfr_wr && sfr_addr == `FSPC_ADDR_ADDR_LOW && !trigger_q)
                addr_lo_q <= sfr_wdata;
            // Config byte program updates the shadowed brown-out byte
            if (state_q == ST_RUN && flash_done && area == `FSPC_AREA_CFG && is_write) begin
                if (func == `FSPC_FN_ERASE)
                    brownout_cfg_q <= `FSPC_RST_BROWNOUT_CFG;
                else if (target == 16'h0002)
                    brownout_cfg_q <= brownout_cfg_q & data_q;
            end
        end
    end

    // Operation sequencer and fault flag
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            trigger_q <= 1'b0;
            fault_q <= 1'b0;
            timer_q <= 23'd0;
            data_q <= `FSPC_RST_DATA;
            flash_req <= 1'b0;
            flash_area <= 2'd0;
            flash_func <= 4'd0;
            flash_addr <= 16'd0;
            flash_wdata <= 8'd0;
        end else begin
            // Software clear loses to a fault raised the same cycle
            if (wr_cc && !sfr_wdata[`FSPC_CC_FAULT])
                fault_q <= 1'b0;
            if (sfr_wr && sfr_addr == `FSPC_ADDR_DATA && !trigger_q)
                data_q <= sfr_wdata;
            flash_req <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        trigger_q <= 1'b1;
                        if (fault_now) begin
                            fault_q <= 1'b1;
                            state_q <= ST_DONE;
                        end else if (func == `FSPC_FN_CID) begin
                            data_q <= COMPANY_CODE;
                            state_q <= ST_DONE;
                        end else if (func == `FSPC_FN_DID) begin
                            data_q <= target[0] ? DEVICE_CODE[15:8] : DEVICE_CODE[7:0];
                            state_q <= ST_DONE;
                        end else begin
                            flash_req <= 1'b1;
                            flash_area <= area;
                            flash_func <= func;
                            flash_wdata <= data_q;
                            if (func == `FSPC_FN_ERASE)
                                flash_addr <= target & `FSPC_PAGE_MASK;
                            else
                                flash_addr <= target;
                            timer_q <= (func == `FSPC_FN_ERASE) ? ERASE_CYC[22:0] :
                                (func == `FSPC_FN_PROG) ? PROG_CYC[22:0] : READ_CYC[22:0];
                            state_q <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    // Finish on the array's done or the nominal time
                    if (timer_q != 23'd0)
                        timer_q <= timer_q - 23'd1;
                    if (flash_done || timer_q == 23'd0) begin
                        if (!erase_prog)
                            data_q <= flash_rdata;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    trigger_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Read data is registered; unmapped addresses return zero
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `FSPC_ADDR_CHIP_CONTROL: sfr_rdata <= {1'b0, fault_q, 5'b00000, prog_en_q};
                `FSPC_ADDR_TRIGGER: sfr_rdata <= 8'h00;
                `FSPC_ADDR_UPDATE_EN: sfr_rdata <= update_en_q;
                `FSPC_ADDR_ADDR_LOW: sfr_rdata <= addr_lo_q;
                `FSPC_ADDR_ADDR_HIGH: sfr_rdata <= addr_hi_q;
                `FSPC_ADDR_DATA: sfr_rdata <= data_q;
                `FSPC_ADDR_COMMAND: sfr_rdata <= command_q;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule // fspc_ctrl
`default_nettype wire

/* shared/fspc_defs.vh */
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH

// Register addresses on the special-function bus
`define FSPC_ADDR_CHIP_CONTROL 8'h9f
`define FSPC_ADDR_TRIGGER 8'ha4
`define FSPC_ADDR_UPDATE_EN 8'ha5
`define FSPC_ADDR_ADDR_LOW 8'ha6
`define FSPC_ADDR_ADDR_HIGH 8'ha7
`define FSPC_ADDR_DATA 8'hae
`define FSPC_ADDR_COMMAND 8'haf
`define FSPC_ADDR_UNLOCK 8'hc7

// Unlock sequence bytes and window length in cycles
`define FSPC_UNLOCK_KEY1 8'haa
`define FSPC_UNLOCK_KEY2 8'h55
`define FSPC_UNLOCK_WINDOW 3'd4

// Reset values
`define FSPC_RST_UPDATE_EN 8'h00
`define FSPC_RST_COMMAND 8'h30
`define FSPC_RST_ADDR 8'h00
`define FSPC_RST_DATA 8'h00
`define FSPC_RST_BROWNOUT_CFG 8'hff

// Field positions
`define FSPC_CC_ENABLE 0
`define FSPC_CC_FAULT 6
`define FSPC_UE_APP 0
`define FSPC_UE_BOOT 1
`define FSPC_UE_CFG 2
`define FSPC_UE_SEC 3
`define FSPC_UE_MAP 4
`define FSPC_CFG2_BOINH 3
`define FSPC_CMD_ERASE_PROG 5
`define FSPC_CMD_AUX 4

// Function codes and areas
`define FSPC_FN_READ 4'h0
`define FSPC_FN_PROG 4'h1
`define FSPC_FN_ERASE 4'h2
`define FSPC_FN_UID 4'h4
`define FSPC_FN_CID 4'hb
`define FSPC_FN_DID 4'hc
`define FSPC_AREA_APP 2'd0
`define FSPC_AREA_BOOT 2'd1
`define FSPC_AREA_SEC 2'd2
`define FSPC_AREA_CFG 2'd3

// Secure area window, config area top and page size
`define FSPC_SEC_LO 16'h0180
`define FSPC_SEC_HI 16'h01ff
`define FSPC_CFG_HI 16'h0005
`define FSPC_PAGE_MASK 16'hff80

// Timing: page erase 5 ms, byte program 23500 ns, at 8 ns clock
`define FSPC_ERASE_NS 5000000
`define FSPC_PROG_NS 23500
`define FSPC_CLK_NS 8

`endif

/* test/fspc_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module fspc_ctrl_chk #(
    parameter ERASE_CYC = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    // CPU side
    input wire logic [15:0] cpu_fetch_addr,
    input wire logic secure_area_selected,
    input wire logic cpu_hold,
    input wire logic internal_fast_oscillator_on,
    // Flash port
    input wire logic flash_req,
    input wire logic [3:0] flash_func,
    input wire logic [15:0] flash_addr,
    input wire logic flash_done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [31:0] hold_cnt_q;
    // Busy length counter; bounds a stuck trigger
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hold_cnt_q <= 32'h0;
        end else begin
            hold_cnt_q <= cpu_hold ? hold_cnt_q + 32'h1 : 32'h0;
        end
    end
    // Key pair with no other write in between, then the trigger write
    sequence key_s;
        sfr_wr && sfr_addr == 8'hc7 && sfr_wdata == 8'haa ##1 !sfr_wr
        ##1 sfr_wr && sfr_addr == 8'hc7 && sfr_wdata == 8'h55 ##1 !sfr_wr;
    endsequence
    sequence trig_s;
        key_s ##1 sfr_wr && sfr_addr == 8'ha4 && sfr_wdata[0]
            && internal_fast_oscillator_on && !cpu_hold;
    endsequence
    unlocked_trigger_a: assert property (trig_s |=> cpu_hold)
        else $error("unlocked trigger ignored");
    hold_cause_a: assert property ($rose(cpu_hold) |-> $past(sfr_wr && sfr_addr == 8'ha4))
        else $error("hold without trigger write");
    req_at_start_a: assert property (flash_req |-> $rose(cpu_hold))
        else $error("array request outside trigger start");
    req_pulse_a: assert property (flash_req |=> !flash_req)
        else $error("array request longer than one cycle");
    osc_while_busy_a: assert property (cpu_hold |-> internal_fast_oscillator_on)
        else $error("oscillator off during operation");
    erase_page_a: assert property (flash_req && flash_func == 4'h2 |-> flash_addr[6:0] == 7'h00)
        else $error("erase address not page aligned");
    done_release_a: assert property (cpu_hold && flash_done |-> ##[1:3] !cpu_hold)
        else $error("hold not released after done");
    hold_bound_a: assert property (hold_cnt_q <= ERASE_CYC + 4)
        else $error("hold too long");
    secure_map_a: assert property (secure_area_selected |-> cpu_fetch_addr[15:7] == 9'h1ff)
        else $error("secure map outside top window");
    addr_stable_a: assert property ($past(cpu_hold) && cpu_hold |-> $stable(flash_addr))
        else $error("address moved during operation");
endmodule // fspc_ctrl_chk
bind fspc_ctrl fspc_ctrl_chk #(.ERASE_CYC(ERASE_CYC)) chk_u (.ref_clk(ref_clk), .nrst(nrst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .cpu_fetch_addr(cpu_fetch_addr),
    .secure_area_selected(secure_area_selected), .cpu_hold(cpu_hold),
    .internal_fast_oscillator_on(internal_fast_oscillator_on), .flash_req(flash_req),
    .flash_func(flash_func), .flash_addr(flash_addr), .flash_done(flash_done));
`default_nettype wire

/* test/tb_flash_self_programming_control.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_flash_self_programming_control;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [2:0] bo = 3'b000; // Low, detect enable, reset enable
    logic [15:0] cpu_fetch_addr = 16'h0000;
    logic flash_done = 1'b0;
    logic [2:0] fl_cnt = 3'd0;
    wire [7:0] sfr_rdata;
    wire sec_sel, cpu_hold, osc_on, flash_req;
    wire [1:0] flash_area;
    wire [3:0] flash_func;
    wire [15:0] flash_addr;
    wire [7:0] flash_wdata;
    logic [15:0] req_addr;
    logic [3:0] req_func;
    logic [1:0] req_area;
    logic [7:0] req_wdata;
    logic [47:0] e;
    int n_mismatch = 0;
    int checks = 0;
    int n_req = 0;
    int cyc = 0;
    int k;
    // bo, enables, command, address, data, fault expected
    localparam logic [47:0] TBL [18] = '{
        48'h0_01_21_0201_55_0, 48'h0_01_22_0233_ff_0, 48'h0_01_21_4800_00_1,
        48'h0_01_23_0200_00_1, 48'h0_01_31_0200_00_1, 48'h0_00_21_0200_00_1,
        48'h0_01_61_0010_00_1, 48'h0_02_61_0010_00_0, 48'h0_01_a1_0180_00_1,
        48'h0_08_a1_0180_00_0, 48'h0_01_e1_0002_00_1, 48'h6_01_21_0201_00_1,
        48'h4_01_21_0201_00_0, 48'h7_01_21_0201_00_0, 48'h0_04_e1_0002_f7_0,
        48'h6_01_21_0201_00_0, 48'h0_00_00_0201_00_0,
        48'h0_00_04_000b_00_0};

    // Identity codes are arbitrary bench values
    fspc_ctrl #(.ERASE_CYC(20), .PROG_CYC(10), .COMPANY_CODE(8'h69),
        .DEVICE_CODE(16'h9617)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .brownout_low(bo[2]), .brownout_detect_enable(bo[1]),
        .brownout_reset_enable(bo[0]), .cpu_fetch_addr(cpu_fetch_addr),
        .secure_area_selected(sec_sel), .cpu_hold(cpu_hold),
        .internal_fast_oscillator_on(osc_on), .flash_req(flash_req), .flash_area(flash_area),
        .flash_func(flash_func), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_done(flash_done), .flash_rdata(8'h3c));

    always #4 ref_clk = ~ref_clk;

    // Array stand-in: done pulse two cycles after a request, inside the read timer
    always @(negedge ref_clk) begin
        flash_done <= (fl_cnt == 3'd1);
        if (flash_req === 1'b1) begin
            fl_cnt <= 3'd2;
        end else if (fl_cnt != 3'd0) begin
            fl_cnt <= fl_cnt - 3'd1;
        end
    end

    // Request capture and hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (flash_req === 1'b1) begin
            n_req <= n_req + 1;
            req_addr <= flash_addr;
            req_func <= flash_func;
            req_area <= flash_area;
            req_wdata <= flash_wdata;
        end
        if (cyc == 6000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle strobes with an idle cycle after, so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        @(negedge ref_clk);
        chk({8'h00, sfr_rdata}, {8'h00, x});
    endtask

    task automatic pwr(input logic [7:0] a, input logic [7:0] d);
        wr(8'hc7, 8'haa);
        wr(8'hc7, 8'h55);
        wr(a, d);
    endtask

    task automatic go();
        int n;
        n = 0;
        pwr(8'ha4, 8'h01);
        while (cpu_hold === 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk({15'h0, cpu_hold}, 16'h0000);
    endtask

    task automatic summarize();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        rd(8'h9f, 8'h00);
        rd(8'ha5, 8'h00);
        rd(8'ha7, 8'h00);
        rd(8'haf, 8'h30);
        chk({15'h0, osc_on}, 16'h0000);
        $display("test reset values done");
        wr(8'h9f, 8'h01);
        rd(8'h9f, 8'h00);
        wr(8'ha5, 8'h1f);
        rd(8'ha5, 8'h00);
        pwr(8'h9f, 8'h01);
        rd(8'h9f, 8'h01);
        chk({15'h0, osc_on}, 16'h0001);
        $display("test protection done");
        pwr(8'ha5, 8'h10);
        cpu_fetch_addr = 16'hff80;
        @(negedge ref_clk);
        chk({15'h0, sec_sel}, 16'h0001);
        cpu_fetch_addr = 16'hff7f;
        @(negedge ref_clk);
        chk({15'h0, sec_sel}, 16'h0000);
        pwr(8'ha5, 8'h00);
        cpu_fetch_addr = 16'hffff;
        @(negedge ref_clk);
        chk({15'h0, sec_sel}, 16'h0000);
        $display("test map done");
        for (int i = 0; i < 18; i++) begin
            e = TBL[i];
            bo = e[46:44];
            pwr(8'ha5, e[43:36]);
            rd(8'ha5, e[43:36]);
            wr(8'haf, e[35:28]);
            wr(8'ha7, e[27:20]);
            wr(8'ha6, e[19:12]);
            wr(8'hae, e[11:4]);
            k = n_req;
            go();
            rd(8'h9f, {1'b0, e[0], 6'h01});
            chk({15'h0, n_req != k}, {15'h0, ~e[0]});
            if (e[0]) begin
                repeat (8) @(negedge ref_clk);
                rd(8'h9f, 8'h41);
                pwr(8'h9f, 8'h01);
                rd(8'h9f, 8'h01);
            end else begin
                chk({14'h0, req_area}, {14'h0, e[35:34]});
                chk({12'h0, req_func}, {12'h0, e[31:28]});
                chk(req_addr, e[31:28] == 4'h2 ? e[27:12] & 16'hff80 : e[27:12]);
                chk({8'h00, req_wdata}, {8'h00, e[11:4]});
            end
        end
        $display("test operations done");
        // Read result, then three identity reads that never reach the array, the last out of range
        rd(8'hae, 8'h3c);
        wr(8'haf, 8'h0b);
        go();
        rd(8'hae, 8'h69);
        wr(8'haf, 8'h0c);
        wr(8'ha6, 8'h01);
        go();
        rd(8'hae, 8'h96);
        wr(8'ha6, 8'h02);
        go();
        rd(8'h9f, 8'h41);
        pwr(8'h9f, 8'h01);
        rd(8'h9f, 8'h01);
        $display("test identity reads done");
        pwr(8'h9f, 8'h00);
        chk({15'h0, osc_on}, 16'h0000);
        $display("test disable done");
        summarize();
    end
endmodule // tb_flash_self_programming_control
`default_nettype wire
